/* File: remote_node.sv */
// Remote serial node model that drives the receive line of the block
`timescale 1ns/1ps
module remote_node (
    input  wire logic clk_i,
    input  wire logic smp_tick_i,
    output logic      line_o = 1'b1
);
    // Hold a level for n sample ticks, sixteen to a bit
    task automatic hold(input logic v, input int n);
        line_o <= v;
        repeat (n) begin
            do
                @(posedge clk_i);
            while (smp_tick_i !== 1'b1);
        end
    endtask : hold
    // Hold a level for n clock cycles
    task automatic hold_clk(input logic v, input int n);
        line_o <= v;
        repeat (n) @(posedge clk_i);
    endtask : hold_clk
    // One character, LSB first, then two stop bits
    task automatic frame(input logic [7:0] b);
        hold(1'b0, 16);
        for (int i = 0; i < 8; i++) hold(b[i], 16);
        hold(1'b1, 32);
    endtask : frame
endmodule : remote_node

/* File: uart_special_cfg.svh */
// Constants for the serial port special-mode logic
`ifndef UART_SPECIAL_CFG_SVH
`define UART_SPECIAL_CFG_SVH
`define LDM_EXT_DRIVER 2'h1
`define LDM_TX_CONTROL 2'h2
`define COMM_MODE_SELECT_INFRARED 2'h2
`define RXM_GENERIC_AUTOBAUD_MODE    2'h2
`define RXM_LIN_AUTOBAUD_MODE    2'h3
`define IRTX_316       2'h0
`define IRTX_FIXED     2'h1
`define IRTX_NONE      2'h2
`define SMP_PER_BIT    8'h10
`define SMP_MID        4'h7
`define BREAK_BITS     8'h0b
`define IR_316_SMP     4'h3
`define SYNC_FALLS     3'h4
`define SYNC_CHAR      8'h55
`define BAUD_MIN       16'h0064
`define BAUD_RST       16'h0000
`endif

/* File: uart_special_modes.sv */
// Special operating modes of the serial port: direction, start detect, auto-baud, infrared
`timescale 1ns/1ps
`include "uart_special_cfg.svh"
module uart_special_modes #(
    parameter int MEAS_W = 18
) (
    input  wire logic                        clk_i,
    input  wire logic                        resetn_i,
    input  wire logic                        smp_tick_i,
    input  wire uart_special_pkg::cfg_s      cfg_i,
    input  wire uart_special_pkg::sleep_e    sleep_i,
    input  wire logic                        other_wake_i,
    input  wire logic                        rx_pin_i,
    input  wire logic                        ev_rx_i,
    input  wire logic                        txd_i,
    input  wire logic                        tx_bit_start_i,
    input  wire logic                        tx_req_i,
    input  wire logic                        tx_done_i,
    input  wire logic                        rx_done_i,
    input  wire logic [7:0]                  rx_data_i,
    input  wire logic                        rx_ninth_i,
    input  wire logic                        rx_stop1_i,
    input  wire logic                        rx_complete_flag_i,
    input  wire logic                        start_flag_clr_i,
    input  wire logic                        sync_err_clr_i,
    input  wire logic                        wfb_set_i,
    output logic                             tx_direction_out_o,
    output logic                             tx_shift_en_o,
    output logic                             tx_pin_o,
    output logic                             tx_pin_oe_o,
    output logic                             rx_line_o,
    output logic                             rx_accept_o,
    output logic                             osc_req_o,
    output logic                             uart_clk_en_o,
    output logic                             wake_o,
    output logic                             clk2x_allowed_o,
    output logic                             baud_load_o,
    output logic [15:0]                      baud_o,
    output uart_special_pkg::status_s        status_o
);
    localparam logic [3:0] SMP_LAST = 4'(`SMP_PER_BIT - 8'h01);
    localparam logic [7:0] BRK_LIM  = 8'(`BREAK_BITS * `SMP_PER_BIT + 8'h01);

    uart_special_pkg::txdir_e tx_r, tx_nxt;
    uart_special_pkg::sd_e    sd_r, sd_nxt;
    uart_special_pkg::ab_e    ab_r, ab_nxt;
    logic [3:0]        gcnt_r, gcnt_nxt, scnt_r, scnt_nxt, dcnt_r, dcnt_nxt;
    logic [7:0]        low_r, low_nxt, pcnt_r, pcnt_nxt;
    logic [6:0]        hw_r, hw_nxt;
    logic [2:0]        falls_r, falls_nxt;
    logic [MEAS_W-1:0] meas_r, meas_nxt;
    logic [15:0]       baud_r, baud_nxt;
    logic              sflag_r, sflag_nxt, serr_r, serr_nxt, wfb_r, wfb_nxt;
    logic              fell_r, fell_nxt, brk_r, brk_nxt, load_r, load_nxt;
    logic              pulse_r, pulse_nxt, dec_r, dec_nxt, src_prev_r, line_prev_r;
    logic              txp_r, txp_nxt;
    logic              ir, src, fall, rise, sd_en, autob, lin, brk_hit, wfb_brk, frame_type;
    logic [MEAS_W-2:0] cand;

    assign ir      = cfg_i.comm_mode_select == `COMM_MODE_SELECT_INFRARED;
    assign src     = cfg_i.one_wire ? txd_i
                   : (cfg_i.ir_event_en ? ev_rx_i : rx_pin_i);
    assign rx_line_o = ir ? ~dec_r : src;
    assign fall    = line_prev_r & ~rx_line_o;
    assign rise    = ~line_prev_r & rx_line_o;
    assign clk2x_allowed_o = ~ir;
    assign frame_type  = cfg_i.char9 ? rx_ninth_i : rx_stop1_i;
    assign rx_accept_o = rx_done_i & (~cfg_i.multiproc_filter_enable | frame_type);

    // Transmit direction and guard time
    always_comb begin
        tx_nxt   = tx_r;
        gcnt_nxt = gcnt_r;
        case (tx_r)
            uart_special_pkg::TXD_IDLE: begin
                gcnt_nxt = 4'h0;
                if (tx_req_i) begin
                    tx_nxt = (cfg_i.line_driver_mode != 2'h0) ? uart_special_pkg::TXD_GUARD
                                                              : uart_special_pkg::TXD_SEND;
                end
            end
            uart_special_pkg::TXD_GUARD: begin
                if (smp_tick_i) begin
                    gcnt_nxt = gcnt_r + 4'h1;
                    if (gcnt_r == SMP_LAST) begin
                        tx_nxt = uart_special_pkg::TXD_SEND;
                    end
                end
            end
            uart_special_pkg::TXD_SEND: begin
                if (tx_done_i) begin
                    tx_nxt = uart_special_pkg::TXD_IDLE;
                end
            end
            default: tx_nxt = uart_special_pkg::TXD_IDLE;
        endcase
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_r   <= uart_special_pkg::TXD_IDLE;
            gcnt_r <= 4'h0;
        end else begin
            tx_r   <= tx_nxt;
            gcnt_r <= gcnt_nxt;
        end
    end
    assign tx_shift_en_o      = tx_r == uart_special_pkg::TXD_SEND;
    assign tx_direction_out_o = (cfg_i.line_driver_mode == `LDM_EXT_DRIVER)
                              & (tx_r != uart_special_pkg::TXD_IDLE);
    assign tx_pin_oe_o = (cfg_i.line_driver_mode == `LDM_TX_CONTROL)
                       ? (tx_r != uart_special_pkg::TXD_IDLE) : 1'b1;

    // Start frame detection in standby
    assign sd_en = cfg_i.start_detect_enable & cfg_i.async_mode
                 & (sleep_i == uart_special_pkg::SLP_STANDBY);
    always_comb begin
        sd_nxt    = sd_r;
        scnt_nxt  = scnt_r;
        sflag_nxt = sflag_r & ~start_flag_clr_i;
        case (sd_r)
            uart_special_pkg::SD_OFF: begin
                if (sd_en) begin
                    sd_nxt = uart_special_pkg::SD_WAIT;
                end
            end
            uart_special_pkg::SD_WAIT: begin
                scnt_nxt = 4'h0;
                if (fall) begin
                    sd_nxt = uart_special_pkg::SD_RUN;
                end
            end
            uart_special_pkg::SD_RUN: begin
                if (smp_tick_i && scnt_r != 4'hf) begin
                    scnt_nxt = scnt_r + 4'h1;
                end
                if (smp_tick_i && scnt_r == `SMP_MID) begin
                    if (rx_line_o && !other_wake_i) begin
                        sd_nxt = uart_special_pkg::SD_WAIT;
                    end else if (!rx_line_o) begin
                        sflag_nxt = 1'b1;
                    end
                end
                if (rx_done_i) begin
                    sd_nxt = uart_special_pkg::SD_WAIT;
                end
            end
            default: sd_nxt = uart_special_pkg::SD_OFF;
        endcase
        if (!sd_en) begin
            sd_nxt = uart_special_pkg::SD_OFF;
        end
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sd_r    <= uart_special_pkg::SD_OFF;
            scnt_r  <= 4'h0;
            sflag_r <= 1'b0;
        end else begin
            sd_r    <= sd_nxt;
            scnt_r  <= scnt_nxt;
            sflag_r <= sflag_nxt;
        end
    end
    assign osc_req_o     = sd_r == uart_special_pkg::SD_RUN;
    assign uart_clk_en_o = osc_req_o & (cfg_i.start_int_en | cfg_i.rx_cmpl_int_en);
    assign wake_o = sd_en & (cfg_i.start_int_en ? sflag_r
                                                : (cfg_i.rx_cmpl_int_en & rx_complete_flag_i));

    // Break detection and auto-baud measurement
    assign lin     = cfg_i.receive_mode_select == `RXM_LIN_AUTOBAUD_MODE;
    assign autob   = lin | (cfg_i.receive_mode_select == `RXM_GENERIC_AUTOBAUD_MODE);
    assign wfb_brk = wfb_r & fell_r & rise;
    assign brk_hit = autob & ((smp_tick_i & ~rx_line_o & (low_r == BRK_LIM - 8'h01))
                            | wfb_brk);
    assign cand    = meas_r[MEAS_W-1:1];
    always_comb begin
        ab_nxt    = ab_r;
        low_nxt   = low_r;
        falls_nxt = falls_r;
        meas_nxt  = meas_r;
        baud_nxt  = baud_r;
        load_nxt  = 1'b0;
        brk_nxt   = brk_hit;
        serr_nxt  = serr_r & ~sync_err_clr_i;
        wfb_nxt   = wfb_r;
        fell_nxt  = fell_r;
        if (rx_line_o) begin
            low_nxt = 8'h00;
        end else if (smp_tick_i && low_r != 8'hff) begin
            low_nxt = low_r + 8'h01;
        end
        if (wfb_r && fall) begin
            fell_nxt = 1'b1;
        end
        if (wfb_brk || !wfb_r) begin
            wfb_nxt  = 1'b0;
            fell_nxt = 1'b0;
        end
        if (wfb_set_i) begin
            wfb_nxt = 1'b1;
        end
        case (ab_r)
            uart_special_pkg::AB_IDLE: ;
            uart_special_pkg::AB_BRK: begin
                meas_nxt  = '0;
                falls_nxt = 3'h0;
                if (fall) begin
                    ab_nxt = uart_special_pkg::AB_MEAS;
                end
            end
            uart_special_pkg::AB_MEAS: begin
                if (meas_r != '1) begin
                    meas_nxt = meas_r + MEAS_W'(1);
                end
                if (fall) begin
                    falls_nxt = falls_r + 3'h1;
                    if (falls_r == `SYNC_FALLS - 3'h1) begin
                        ab_nxt = uart_special_pkg::AB_CHK;
                    end
                end
            end
            uart_special_pkg::AB_CHK: begin
                if (rx_done_i) begin
                    ab_nxt = uart_special_pkg::AB_IDLE;
                    if (lin && rx_data_i != `SYNC_CHAR) begin
                        serr_nxt = 1'b1;
                    end else if (lin || (cand[MEAS_W-2:16] == '0
                                         && cand[15:0] >= `BAUD_MIN)) begin
                        baud_nxt = cand[15:0];
                        load_nxt = 1'b1;
                    end
                end
            end
            default: ab_nxt = uart_special_pkg::AB_IDLE;
        endcase
        if (brk_hit) begin
            ab_nxt = uart_special_pkg::AB_BRK;
        end
        if (!autob) begin
            ab_nxt = uart_special_pkg::AB_IDLE;
        end
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ab_r    <= uart_special_pkg::AB_IDLE;
            low_r   <= 8'h00;
            falls_r <= 3'h0;
            meas_r  <= '0;
            baud_r  <= `BAUD_RST;
            load_r  <= 1'b0;
            brk_r   <= 1'b0;
            serr_r  <= 1'b0;
            wfb_r   <= 1'b0;
            fell_r  <= 1'b0;
        end else begin
            ab_r    <= ab_nxt;
            low_r   <= low_nxt;
            falls_r <= falls_nxt;
            meas_r  <= meas_nxt;
            baud_r  <= baud_nxt;
            load_r  <= load_nxt;
            brk_r   <= brk_nxt;
            serr_r  <= serr_nxt;
            wfb_r   <= wfb_nxt;
            fell_r  <= fell_nxt;
        end
    end
    assign baud_o      = baud_r;
    assign baud_load_o = load_r;
    assign status_o    = '{start_detect_flag: sflag_r, sync_field_error_flag: serr_r,
                           wait_break_flag: wfb_r, break_seen: brk_r};

    // Infrared encoder and decoder
    always_comb begin
        pulse_nxt = pulse_r;
        pcnt_nxt  = pcnt_r;
        hw_nxt    = hw_r;
        dec_nxt   = dec_r;
        dcnt_nxt  = dcnt_r;
        if (!ir) begin
            pulse_nxt = 1'b0;
        end else if (tx_bit_start_i && !txd_i && cfg_i.ir_tx_mode != `IRTX_NONE) begin
            pulse_nxt = 1'b1;
            pcnt_nxt  = 8'h00;
        end else if (pulse_r && cfg_i.ir_tx_mode == `IRTX_316) begin
            if (smp_tick_i) begin
                pcnt_nxt = pcnt_r + 8'h01;
                if (pcnt_r[3:0] == `IR_316_SMP - 4'h1) begin
                    pulse_nxt = 1'b0;
                end
            end
        end else if (pulse_r) begin
            pcnt_nxt = pcnt_r + 8'h01;
            if ({1'b0, pcnt_r} + 9'h001 >= {1'b0, cfg_i.ir_tx_len}) begin
                pulse_nxt = 1'b0;
            end
        end
        txp_nxt = (ir && cfg_i.ir_tx_mode != `IRTX_NONE) ? ~pulse_nxt : txd_i;
        if (!src) begin
            hw_nxt = (hw_r != 7'h7f) ? hw_r + 7'h01 : hw_r;
        end else begin
            hw_nxt = 7'h00;
        end
        if (dec_r && smp_tick_i) begin
            dcnt_nxt = dcnt_r + 4'h1;
            if (dcnt_r == SMP_LAST) begin
                dec_nxt = 1'b0;
            end
        end
        if (ir && !src_prev_r && src && hw_r >= cfg_i.ir_rx_min) begin
            dec_nxt  = 1'b1;
            dcnt_nxt = 4'h0;
        end
        if (!ir) begin
            dec_nxt = 1'b0;
        end
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pulse_r     <= 1'b0;
            pcnt_r      <= 8'h00;
            hw_r        <= 7'h00;
            dec_r       <= 1'b0;
            dcnt_r      <= 4'h0;
            txp_r       <= 1'b1;
            src_prev_r  <= 1'b1;
            line_prev_r <= 1'b1;
        end else begin
            pulse_r     <= pulse_nxt;
            pcnt_r      <= pcnt_nxt;
            hw_r        <= hw_nxt;
            dec_r       <= dec_nxt;
            dcnt_r      <= dcnt_nxt;
            txp_r       <= txp_nxt;
            src_prev_r  <= src;
            line_prev_r <= rx_line_o;
        end
    end
    assign tx_pin_o = txp_r;

    a_dir_guard: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(tx_shift_en_o) && cfg_i.line_driver_mode == `LDM_EXT_DRIVER
        |-> $past(tx_direction_out_o))
        else $error("shifting began without guard time");
    a_dir_frame: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tx_shift_en_o && !tx_done_i && cfg_i.line_driver_mode == `LDM_EXT_DRIVER
        |=> tx_direction_out_o)
        else $error("direction dropped inside frame");
    a_sd_sleep: assert property (@(posedge clk_i) disable iff (!resetn_i)
        sleep_i != uart_special_pkg::SLP_STANDBY |=> !osc_req_o)
        else $error("start detect active outside standby");
    a_sd_edge: assert property (@(posedge clk_i) disable iff (!resetn_i)
        sd_r == uart_special_pkg::SD_WAIT && fall && sd_en |=> osc_req_o)
        else $error("falling edge did not start oscillator");
    a_wake_sel: assert property (@(posedge clk_i) disable iff (!resetn_i)
        sd_en && cfg_i.start_int_en && sflag_r |-> wake_o)
        else $error("start flag did not wake");
    a_sync_bad: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ab_r == uart_special_pkg::AB_CHK && rx_done_i && lin && rx_data_i != `SYNC_CHAR
        && !brk_hit |=> serr_r && !baud_load_o && $stable(baud_o))
        else $error("bad sync not flagged");
    a_baud_range: assert property (@(posedge clk_i) disable iff (!resetn_i)
        baud_load_o && !lin |-> baud_o >= `BAUD_MIN)
        else $error("baud loaded out of range");
    a_mp_filter: assert property (@(posedge clk_i) disable iff (!resetn_i)
        cfg_i.multiproc_filter_enable && rx_done_i && !frame_type |-> !rx_accept_o)
        else $error("data frame passed filter");
    a_ir_2x: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ir |-> !clk2x_allowed_o)
        else $error("double speed allowed in infrared mode");
    a_ir_short: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ir && !dec_r && !src_prev_r && src && hw_r < cfg_i.ir_rx_min |=> !dec_r)
        else $error("short pulse decoded as zero");
endmodule : uart_special_modes

/* File: uart_special_modes_tb.sv */
// Self-checking testbench for the serial port special-mode logic
`timescale 1ns/1ps
`include "uart_special_cfg.svh"
module uart_special_modes_tb;
    logic clk_i, resetn_i, smp_tick_i, other_wake_i, rx_pin_i, ev_rx_i, txd_i;
    logic tx_bit_start_i, tx_req_i, tx_done_i, rx_done_i, rx_ninth_i, rx_stop1_i;
    logic rx_complete_flag_i, start_flag_clr_i, sync_err_clr_i, wfb_set_i, rx_accept_o;
    logic tx_direction_out_o, tx_shift_en_o, tx_pin_o, tx_pin_oe_o, rx_line_o, osc_req_o;
    logic uart_clk_en_o, wake_o, clk2x_allowed_o, baud_load_o;
    logic [7:0]                rx_data_i;
    logic [15:0]               baud_o, lastb;
    uart_special_pkg::cfg_s    cfg_i;
    uart_special_pkg::sleep_e  sleep_i;
    uart_special_pkg::status_s status_o;
    uart_special_pkg::sleep_e  sl[4] = '{uart_special_pkg::SLP_ACTIVE,
        uart_special_pkg::SLP_IDLE, uart_special_pkg::SLP_PDOWN, uart_special_pkg::SLP_STANDBY};
    int error_cnt, num_checks, div, tcnt, brk_cnt, n, m, k;
    uart_special_modes dut (.*);
    remote_node node (.clk_i(clk_i), .smp_tick_i(smp_tick_i), .line_o(rx_pin_i));
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        tcnt <= (tcnt >= div - 1) ? 0 : tcnt + 1;
        smp_tick_i <= (tcnt == 0);
        if (status_o.break_seen === 1'b1) brk_cnt <= brk_cnt + 1;
    end
    function automatic logic exp_acc();
        return rx_done_i & (!cfg_i.multiproc_filter_enable
            | (cfg_i.char9 ? rx_ninth_i : rx_stop1_i));
    endfunction : exp_acc
    function automatic logic [15:0] exp_baud(input int d);
        return 16'(8 * 16 * d / 2);
    endfunction : exp_baud
    function automatic logic exp_load(input logic [1:0] md, input logic [7:0] dt, input int d);
        return (md == `RXM_LIN_AUTOBAUD_MODE) ? (dt == `SYNC_CHAR) : (exp_baud(d) >= `BAUD_MIN);
    endfunction : exp_load
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic bail();
        error_cnt++;
        $display("Error at %0t: wait limit used up", $time);
        report_and_stop();
    endtask : bail
    task automatic ab(input logic [1:0] md, input int d, input logic [7:0] dt);
        int k0;
        @(posedge clk_i);
        cfg_i.receive_mode_select <= md;
        div <= d;
        k0 = brk_cnt;
        node.hold(1'b0, 176);
        #1 chk(16'(brk_cnt - k0), 16'h0);
        node.hold(1'b0, 16);
        node.hold(1'b1, 16);
        chk(16'(brk_cnt - k0), 16'h1);
        node.frame(8'h55);
        rx_data_i <= dt;
        rx_done_i <= 1'b1;
        @(posedge clk_i);
        rx_done_i <= 1'b0;
        if (exp_load(md, dt, d)) lastb = exp_baud(d);
        #1 chk(baud_load_o, exp_load(md, dt, d));
        chk(baud_o, lastb);
        chk(status_o.sync_field_error_flag, md == `RXM_LIN_AUTOBAUD_MODE && dt != `SYNC_CHAR);
        sync_err_clr_i <= 1'b1;
        @(posedge clk_i);
        sync_err_clr_i <= 1'b0;
        $display("Auto-baud case done");
    endtask : ab
    task automatic irtx(input logic [1:0] md, input int lo, input int hi);
        @(posedge clk_i);
        cfg_i.ir_tx_mode <= md;
        txd_i <= 1'b0;
        tx_bit_start_i <= 1'b1;
        @(posedge clk_i);
        tx_bit_start_i <= 1'b0;
        n = 0;
        repeat (80) begin
            #1 n += (tx_pin_o === 1'b0);
            @(posedge clk_i);
        end
        txd_i <= 1'b1;
        chk(16'(n >= lo && n <= hi), 16'h1);
    endtask : irtx
    initial begin
        #2000000 bail();
    end
    initial begin
        {clk_i, resetn_i, other_wake_i, tx_bit_start_i, tx_req_i} = '0;
        {tx_done_i, rx_done_i, rx_ninth_i, rx_stop1_i, rx_complete_flag_i} = '0;
        {start_flag_clr_i, sync_err_clr_i, wfb_set_i, rx_data_i, lastb} = '0;
        {ev_rx_i, txd_i} = 2'h3;
        cfg_i = '0;
        cfg_i.async_mode = 1'b1;
        sleep_i = uart_special_pkg::SLP_ACTIVE;
        {error_cnt, num_checks} = '0;
        div = 4;
        void'($urandom(32'hb096));
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (40) begin
            @(posedge clk_i);
            {rx_ninth_i, rx_stop1_i, rx_done_i, txd_i} <= 4'($urandom);
            cfg_i.multiproc_filter_enable <= 1'($urandom);
            cfg_i.char9 <= 1'($urandom);
            cfg_i.one_wire <= 1'($urandom);
            cfg_i.comm_mode_select <= 2'($urandom) & `COMM_MODE_SELECT_INFRARED;
            #1 chk(rx_accept_o, exp_acc());
            chk(clk2x_allowed_o, cfg_i.comm_mode_select != `COMM_MODE_SELECT_INFRARED);
            if (cfg_i.comm_mode_select != `COMM_MODE_SELECT_INFRARED)
                chk(rx_line_o, cfg_i.one_wire ? txd_i : rx_pin_i);
        end
        {cfg_i.multiproc_filter_enable, cfg_i.char9, cfg_i.one_wire, cfg_i.comm_mode_select} <= 5'h00;
        {rx_done_i, txd_i} <= 2'h1;
        $display("Filter and line select test done");
        for (m = 0; m < 3; m++) begin
            @(posedge clk_i);
            cfg_i.line_driver_mode <= 2'(m);
            tx_req_i <= 1'b1;
            @(posedge clk_i);
            tx_req_i <= 1'b0;
            n = 0;
            #1 chk(tx_shift_en_o, m == 0);
            for (k = 0; k < 400 && tx_shift_en_o !== 1'b1; k++) begin
                chk(tx_direction_out_o, m == 1);
                chk(tx_pin_oe_o, 1'b1);
                n += smp_tick_i;
                @(posedge clk_i);
                #1;
            end
            if (k == 400) bail();
            chk(16'(n), (m == 0) ? 16'h0 : 16'h10);
            repeat (20) @(posedge clk_i);
            #1 chk(tx_direction_out_o, m == 1);
            tx_done_i <= 1'b1;
            @(posedge clk_i);
            tx_done_i <= 1'b0;
            #1 chk({tx_direction_out_o, tx_shift_en_o}, 16'h0);
            chk(tx_pin_oe_o, m != 2);
        end
        $display("Direction test done");
        cfg_i.start_detect_enable <= 1'b1;
        sleep_i <= uart_special_pkg::SLP_STANDBY;
        repeat (3) @(posedge clk_i);
        node.hold(1'b0, 2);
        #1 chk(osc_req_o, 1'b1);
        chk(uart_clk_en_o, 1'b0);
        node.hold(1'b1, 20);
        #1 chk({osc_req_o, status_o.start_detect_flag}, 16'h0);
        other_wake_i <= 1'b1;
        node.hold(1'b0, 2);
        node.hold(1'b1, 20);
        #1 chk(osc_req_o, 1'b1);
        {rx_done_i, other_wake_i} <= 2'h2;
        @(posedge clk_i);
        rx_done_i <= 1'b0;
        cfg_i.start_int_en <= 1'b1;
        node.hold(1'b0, 16);
        #1 chk({status_o.start_detect_flag, wake_o, uart_clk_en_o}, 16'h7);
        node.hold(1'b1, 16);
        {rx_done_i, start_flag_clr_i} <= 2'h3;
        @(posedge clk_i);
        {rx_done_i, start_flag_clr_i} <= 2'h0;
        @(posedge clk_i);
        #1 chk({osc_req_o, status_o.start_detect_flag, wake_o}, 16'h0);
        {cfg_i.start_int_en, cfg_i.rx_cmpl_int_en, rx_complete_flag_i} <= 3'h3;
        #1 chk(wake_o, 1'b1);
        rx_complete_flag_i <= 1'b0;
        for (m = 0; m < 4; m++) begin
            sleep_i <= sl[m];
            cfg_i.async_mode <= (m != 3);
            node.hold(1'b0, 12);
            #1 chk(osc_req_o, 1'b0);
            node.hold(1'b1, 16);
        end
        {cfg_i.start_detect_enable, cfg_i.async_mode} <= 2'h1;
        sleep_i <= uart_special_pkg::SLP_ACTIVE;
        $display("Start detect test done");
        ab(`RXM_LIN_AUTOBAUD_MODE, 4, 8'h55);
        ab(`RXM_LIN_AUTOBAUD_MODE, 4, 8'h54);
        ab(`RXM_GENERIC_AUTOBAUD_MODE, 4, 8'($urandom));
        ab(`RXM_GENERIC_AUTOBAUD_MODE, 1, 8'h55);
        ab(`RXM_GENERIC_AUTOBAUD_MODE, 2, 8'h00);
        wfb_set_i <= 1'b1;
        @(posedge clk_i);
        wfb_set_i <= 1'b0;
        #1 chk(status_o.wait_break_flag, 1'b1);
        n = brk_cnt;
        node.hold(1'b0, 2);
        node.hold(1'b1, 2);
        #1 chk(16'(brk_cnt - n), 16'h1);
        chk(status_o.wait_break_flag, 1'b0);
        $display("Wait-for-break test done");
        m = 4 + $urandom % 20;
        cfg_i.comm_mode_select <= `COMM_MODE_SELECT_INFRARED;
        cfg_i.ir_tx_len <= 8'(m);
        irtx(`IRTX_FIXED, m, m);
        irtx(`IRTX_316, 2 * div + 1, 3 * div);
        cfg_i.ir_tx_mode <= `IRTX_NONE;
        repeat (8) begin
            @(posedge clk_i);
            txd_i <= 1'($urandom);
            @(posedge clk_i);
            #1 chk(tx_pin_o, txd_i);
        end
        txd_i <= 1'b1;
        cfg_i.ir_rx_min <= 7'(m);
        for (k = 0; k < 3; k++) begin
            cfg_i.ir_event_en <= (k == 2);
            node.hold_clk(1'b0, (k == 1) ? m - 1 : m);
            node.hold_clk(1'b1, 1);
            n = 0;
            repeat (150) begin
                @(posedge clk_i);
                #1 n += (rx_line_o === 1'b0);
            end
            chk(16'(n > 0), 16'(k == 0));
        end
        $display("Infrared test done");
        report_and_stop();
    end
endmodule : uart_special_modes_tb

/* File: uart_special_pkg.sv */
// Types for the serial port special-mode logic
package uart_special_pkg;
    typedef enum logic [1:0] {SLP_ACTIVE, SLP_IDLE, SLP_STANDBY, SLP_PDOWN} sleep_e;
    typedef enum logic [1:0] {TXD_IDLE, TXD_GUARD, TXD_SEND} txdir_e;
    typedef enum logic [1:0] {SD_OFF, SD_WAIT, SD_RUN} sd_e;
    typedef enum logic [1:0] {AB_IDLE, AB_BRK, AB_MEAS, AB_CHK} ab_e;
    typedef struct packed {
        logic [1:0] line_driver_mode;
        logic       start_detect_enable;
        logic       async_mode;
        logic [1:0] receive_mode_select;
        logic       multiproc_filter_enable;
        logic       char9;
        logic [1:0] comm_mode_select;
        logic       one_wire;
        logic       ir_event_en;
        logic [1:0] ir_tx_mode;
        logic [7:0] ir_tx_len;
        logic [6:0] ir_rx_min;
        logic       start_int_en;
        logic       rx_cmpl_int_en;
    } cfg_s;
    typedef struct packed {
        logic start_detect_flag;
        logic sync_field_error_flag;
        logic wait_break_flag;
        logic break_seen;
    } status_s;
endpackage : uart_special_pkg
